// ==== verilog/nvs_host_ctrl.sv ====
/*
 Host controller for an asynchronous nonvolatile SRAM port: issues read and
 write cycles, the six-read software save/restore sequence and the hardware
 save pulse. Assumes all inputs synchronous to ref_clk and a 32-bit part.
*/
// Functional notes
// - Command sequence steps use read cycles only, ended by select edge.
// - Six reads in order with write enable high throughout.
// - Each sequence read lasts at least the sequence cycle time.
// - Data from the sixth sequence read is discarded.
// - Hardware save pin held low at least the minimum pulse.
// - Save pin kept high during ordinary reads and writes.
`timescale 1ns/1ps
`default_nettype none
module nvs_host_ctrl
#(
   parameter int SAVE_WAIT    = nvs_pkg::SAVE_CYCLES,
   parameter int RESTORE_WAIT = nvs_pkg::RESTORE_CYCLES,
   parameter int CMD_WAIT     = nvs_pkg::CMD_PROC_CYCLES
)
(
   input  wire logic                        ref_clk,
   input  wire logic                        rstn,
   input  wire logic                        req_valid,
   output var  logic                        req_ready,
   input  wire nvs_pkg::nvs_req_type        req,
   output var  logic                        rsp_valid,
   output var  logic [nvs_pkg::DATA_W-1:0]  rsp_data,
   output var  nvs_pkg::nvs_pins_type       pins,
   input  wire logic [nvs_pkg::DATA_W-1:0]  dq_in,
   output var  logic                        hw_save_req_n_out,
   output var  logic                        hw_save_req_n_oe,
   input  wire logic                        hw_save_req_n_in
);
   localparam int TW = 24;

   default clocking nvs_cb @(posedge ref_clk);
   endclocking
   default disable iff (!rstn);

   if (SAVE_WAIT < 1 || RESTORE_WAIT < 1 || CMD_WAIT < 1
       || SAVE_WAIT + CMD_WAIT >= (1 << TW)
       || RESTORE_WAIT + CMD_WAIT >= (1 << TW))
      $error("nvs_host_ctrl: wait counts out of range");

   typedef enum logic [2:0] {
      NVS_IDLE,
      NVS_CYCLE,
      NVS_GAP,
      NVS_HSB,
      NVS_BUSY
   } nvs_state_type;

   typedef struct packed {
      nvs_state_type         st;
      nvs_pkg::nvs_req_type  cur;
      logic [2:0]            step;
      logic                  rsp;
      logic [nvs_pkg::DATA_W-1:0] data;
      nvs_pkg::nvs_pins_type p;
      logic                  hsb_drive;
   } nvs_ctrl_type;

   nvs_ctrl_type s;
   nvs_ctrl_type next_s;
   logic         t_load;
   logic [TW-1:0] t_value;
   logic         t_done;

   nvs_timer #(.W(TW)) u_timer
   (
      .ref_clk (ref_clk),
      .rstn    (rstn),
      .load    (t_load),
      .value   (t_value),
      .done    (t_done)
   );

   function automatic logic [18:0] seq_addr(input logic [2:0] i,
                                            input logic save);
      logic [18:0] a;
      a = nvs_pkg::SEQ_ADDR0;
      unique case (i)
         3'd0: a = nvs_pkg::SEQ_ADDR0;
         3'd1: a = nvs_pkg::SEQ_ADDR1;
         3'd2: a = nvs_pkg::SEQ_ADDR2;
         3'd3: a = nvs_pkg::SEQ_ADDR3;
         3'd4: a = nvs_pkg::SEQ_ADDR4;
         default: a = save ? nvs_pkg::SAVE_ADDR_LAST
                           : nvs_pkg::RESTORE_ADDR_LAST;
      endcase
      return a;
   endfunction

   function automatic nvs_pkg::nvs_pins_type idle_pins();
      nvs_pkg::nvs_pins_type q;
      q = '0;
      q.chip_sel_first_n = 1'b1;
      q.write_en_n = 1'b1;
      q.out_en_n   = 1'b1;
      q.lane_en_n  = '1;
      return q;
   endfunction

   ///////////////////////////////////////////////////////////////////////
   always_comb
   begin
      next_s = s;
      next_s.rsp = 1'b0;
      t_load = 1'b0;
      t_value = '0;
      unique case (s.st)
         NVS_IDLE:
         begin
            next_s.p = idle_pins();
            if (req_valid)
            begin
               next_s.cur  = req;
               next_s.step = 3'd0;
               if (req.op == nvs_pkg::NVS_OP_SAVE && req.lane_en[0])
               begin
                  next_s.st = NVS_HSB;
                  next_s.hsb_drive = 1'b1;
               end
               else
               begin
                  next_s.st = NVS_CYCLE;
                  // Select with first low, second high
                  next_s.p.chip_sel_first_n = 1'b0;
                  next_s.p.chip_sel_second  = 1'b1;
                  if (req.op == nvs_pkg::NVS_OP_WRITE)
                  begin
                     next_s.p.write_en_n = 1'b0;
                     next_s.p.addr       = req.addr;
                     next_s.p.lane_en_n  = ~req.lane_en;
                     next_s.p.dq_out     = req.wdata;
                     next_s.p.dq_oe      = req.lane_en;
                  end
                  else if (req.op == nvs_pkg::NVS_OP_READ)
                  begin
                     // Read with outputs enabled per lane
                     next_s.p.out_en_n  = 1'b0;
                     next_s.p.addr      = req.addr;
                     next_s.p.lane_en_n = ~req.lane_en;
                  end
                  else
                  begin
                     // First sequence read, write enable high
                     next_s.p.out_en_n  = 1'b0;
                     next_s.p.lane_en_n = '0;
                     next_s.p.addr = seq_addr(3'd0,
                        req.op == nvs_pkg::NVS_OP_SAVE);
                  end
               end
            end
         end
         NVS_CYCLE:
         begin
            // One full clock per cycle exceeds the cycle time
            next_s.data = dq_in;
            // Cycle ended by the select edge
            next_s.p = idle_pins();
            next_s.st = NVS_GAP;
         end
         NVS_GAP:
         begin
            if (s.cur.op == nvs_pkg::NVS_OP_READ
                || s.cur.op == nvs_pkg::NVS_OP_WRITE)
            begin
               next_s.rsp = (s.cur.op == nvs_pkg::NVS_OP_READ);
               next_s.st = NVS_IDLE;
            end
            else if (s.step == 3'(nvs_pkg::SEQ_LEN - 1))
            begin
               t_load = 1'b1;
               t_value = (s.cur.op == nvs_pkg::NVS_OP_SAVE)
                  ? TW'(SAVE_WAIT + CMD_WAIT)
                  : TW'(RESTORE_WAIT + CMD_WAIT);
               next_s.st = NVS_BUSY;
            end
            else
            begin
               next_s.step = s.step + 3'd1;
               next_s.st = NVS_CYCLE;
               next_s.p.chip_sel_first_n = 1'b0;
               next_s.p.chip_sel_second  = 1'b1;
               next_s.p.out_en_n  = 1'b0;
               next_s.p.lane_en_n = '0;
               next_s.p.addr = seq_addr(s.step + 3'd1,
                  s.cur.op == nvs_pkg::NVS_OP_SAVE);
            end
         end
         NVS_HSB:
         begin
            // Pin released before any further access
            next_s.hsb_drive = 1'b0;
            t_load = 1'b1;
            t_value = TW'(SAVE_WAIT);
            next_s.st = NVS_BUSY;
         end
         NVS_BUSY:
         begin
            // No access issued while the device is busy
            if (t_done && hw_save_req_n_in)
               next_s.st = NVS_IDLE;
         end
         default:
            next_s.st = NVS_IDLE;
      endcase
   end

   always_ff @(posedge ref_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         s <= '0;
         s.st <= NVS_IDLE;
         s.p.chip_sel_first_n <= 1'b1;
         s.p.write_en_n <= 1'b1;
         s.p.out_en_n <= 1'b1;
         s.p.lane_en_n <= '1;
      end
      else
         s <= next_s;
   end

   ///////////////////////////////////////////////////////////////////////
   assign req_ready = (s.st == NVS_IDLE);
   assign rsp_valid = s.rsp;
   // Sequence reads never produce a response
   assign rsp_data = s.data;
   assign pins = s.p;
   assign hw_save_req_n_out = 1'b0;
   assign hw_save_req_n_oe = s.hsb_drive;

   ///////////////////////////////////////////////////////////////////////
   // Write enable high
   a_seq_we_high: assert property
      ((s.cur.op inside {nvs_pkg::NVS_OP_SAVE, nvs_pkg::NVS_OP_RESTORE}
       && s.st inside {NVS_CYCLE, NVS_GAP}) |-> pins.write_en_n)
      else $error("write enable low during command sequence");
   a_hsb_pulse_len: assert property
      ($rose(hw_save_req_n_oe) |-> hw_save_req_n_oe[*1] ##1 !hw_save_req_n_oe)
      else $error("save pulse length wrong");
   a_hsb_off_access: assert property
      (!pins.chip_sel_first_n |-> !hw_save_req_n_oe)
      else $error("save pin driven during access");
   a_sel_combo: assert property
      (!pins.chip_sel_first_n |-> pins.chip_sel_second)
      else $error("select pair illegal");
   a_write_drive: assert property
      ((pins.dq_oe != '0) |-> (!pins.write_en_n && !pins.chip_sel_first_n
       && pins.dq_oe == ~pins.lane_en_n))
      else $error("data driven outside write lanes");
   a_read_float: assert property
      (!pins.out_en_n |-> (pins.dq_oe == '0 && pins.write_en_n))
      else $error("host drives data during read");
   a_cycle_end: assert property
      ((s.st == NVS_CYCLE) |=> pins.chip_sel_first_n && pins.out_en_n)
      else $error("cycle not ended by select edge");
   a_busy_quiet: assert property
      ((s.st == NVS_BUSY) |-> pins.chip_sel_first_n && !req_ready)
      else $error("access during busy");
endmodule
`default_nettype wire

// ==== verilog/nvs_pkg.sv ====
/*
 Constants and carrier types for the host-side controller of an
 asynchronous nonvolatile SRAM port. Assumes a 20 MHz controller clock.
*/
`default_nettype none
package nvs_pkg;
   localparam int CLK_PERIOD_NS = 50;
   // Timing figures in their own units
   localparam int SEQ_CYCLE_TIME_NS       = 45;
   localparam int HW_SAVE_PULSE_MIN_NS    = 15;
   localparam int CMD_PROCESSING_TIME_US  = 500;
   localparam int RESTORE_DURATION_US     = 600;
   localparam int SAVE_DURATION_MS        = 8;
   localparam int HW_SAVE_OUTPUT_RETURN_NS = 25;
   // Derived cycle counts: minimums round up
   localparam int SEQ_CYCLES =
      (SEQ_CYCLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int HSB_PULSE_CYCLES =
      (HW_SAVE_PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CMD_PROC_CYCLES =
      CMD_PROCESSING_TIME_US * 1000 / CLK_PERIOD_NS;
   localparam int RESTORE_CYCLES =
      RESTORE_DURATION_US * 1000 / CLK_PERIOD_NS;
   localparam int SAVE_CYCLES =
      SAVE_DURATION_MS * 1000000 / CLK_PERIOD_NS;
   localparam int HSB_RETURN_CYCLES = 1;
   localparam int SEQ_LEN = 6;
   localparam int ADDR_W  = 19;
   localparam int DATA_W  = 32;
   localparam int LANES   = 4;
   // Default command addresses; real values depend on the command table
   localparam logic [18:0] SEQ_ADDR0 = 19'h0_0000;
   localparam logic [18:0] SEQ_ADDR1 = 19'h0_0001;
   localparam logic [18:0] SEQ_ADDR2 = 19'h0_0002;
   localparam logic [18:0] SEQ_ADDR3 = 19'h0_0003;
   localparam logic [18:0] SEQ_ADDR4 = 19'h0_0004;
   localparam logic [18:0] SAVE_ADDR_LAST    = 19'h0_0005;
   localparam logic [18:0] RESTORE_ADDR_LAST = 19'h0_0006;

   typedef enum logic [1:0] {
      NVS_OP_READ,
      NVS_OP_WRITE,
      NVS_OP_SAVE,
      NVS_OP_RESTORE
   } nvs_op_type;

   typedef struct packed {
      nvs_op_type         op;
      logic [ADDR_W-1:0]  addr;
      logic [DATA_W-1:0]  wdata;
      logic [LANES-1:0]   lane_en;
   } nvs_req_type;

   // Pins driven toward the memory; byte enables active low
   typedef struct packed {
      logic               chip_sel_first_n;
      logic               chip_sel_second;
      logic               write_en_n;
      logic               out_en_n;
      logic [LANES-1:0]   lane_en_n;
      logic [ADDR_W-1:0]  addr;
      logic [DATA_W-1:0]  dq_out;
      logic [LANES-1:0]   dq_oe;
   } nvs_pins_type;
endpackage
`default_nettype wire

// ==== verilog/nvs_timer.sv ====
/*
 Down counter used for the busy windows after save and restore.
 Assumes one synchronous clock and an active-low asynchronous reset.
*/
`timescale 1ns/1ps
`default_nettype none
module nvs_timer
#(
   parameter int W = 24
)
(
   input  wire logic         ref_clk,
   input  wire logic         rstn,
   input  wire logic         load,
   input  wire logic [W-1:0] value,
   output var  logic         done
);
   logic [W-1:0] count;
   logic [W-1:0] next_count;

   always_comb
   begin
      next_count = count;
      if (load)
         next_count = value;
      else if (count != '0)
         next_count = count - W'(1);
   end

   always_ff @(posedge ref_clk or negedge rstn)
   begin
      if (!rstn)
         count <= '0;
      else
         count <= next_count;
   end

   assign done = (count == '0) && !load;
endmodule
`default_nettype wire

// ==== testbench/nvs_dev_model.sv ====
/*
 Behavioural memory device for the host controller bench: 16 words,
 save/restore store, six-read command detector, hardware save pin.
 Assumes registered pins from the controller, one idle cycle per access.
*/
`timescale 1ns/1ps
`default_nettype none
module nvs_dev_model
#(
   parameter int BUSY = 10
)
(
   input  wire logic                  ref_clk,
   input  wire logic                  rstn,
   input  wire nvs_pkg::nvs_pins_type pins,
   output var  logic [31:0]           dq_in,
   input  wire logic                  hw_save_req_n_out,
   input  wire logic                  hw_save_req_n_oe,
   output var  logic                  hw_save_req_n_in,
   output var  logic [7:0]            save_count,
   output var  logic [7:0]            restore_count
);
   logic [31:0] mem [16];
   logic [31:0] nv  [16];
   logic [31:0] last_dq;
   logic [2:0]  step;
   logic [7:0]  busy;
   logic        latched;
   logic        dev_drive;
   logic        sel;
   logic        sel_q;
   logic [18:0] want;
   logic [3:0]  a;
   // pin low only from host or own driver, else pull-up
   assign hw_save_req_n_in = !((hw_save_req_n_oe && !hw_save_req_n_out)
                               || dev_drive);
   // select decode, locked while busy or pin low
   assign sel = !pins.chip_sel_first_n && pins.chip_sel_second
                && busy == 8'h00 && hw_save_req_n_in;
   assign a = pins.addr[3:0];
   assign want = (step == 3'd0) ? nvs_pkg::SEQ_ADDR0 :
                 (step == 3'd1) ? nvs_pkg::SEQ_ADDR1 :
                 (step == 3'd2) ? nvs_pkg::SEQ_ADDR2 :
                 (step == 3'd3) ? nvs_pkg::SEQ_ADDR3 : nvs_pkg::SEQ_ADDR4;
   always_comb
   begin
      for (int i = 0; i < 4; i++)
      begin
         if (sel && pins.write_en_n && !pins.out_en_n && !pins.lane_en_n[i])
            dq_in[8*i+:8] = mem[a][8*i+:8];
         else
            dq_in[8*i+:8] = ~last_dq[8*i+:8];
      end
   end
   always_ff @(posedge ref_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         {step, busy, latched, dev_drive, sel_q, last_dq} <= '0;
         save_count <= '0;
         restore_count <= '0;
      end
      else
      begin
         last_dq <= dq_in;
         sel_q <= sel;
         if (busy != 8'h00)
            busy <= busy - 8'h01;
         if (busy == 8'h01)
            dev_drive <= 1'b0;
         // a write lands on enabled lanes and resets matching
         if (sel && !sel_q && !pins.write_en_n)
         begin
            for (int i = 0; i < 4; i++)
               if (!pins.lane_en_n[i])
                  mem[a][8*i+:8] <= pins.dq_out[8*i+:8];
            latched <= 1'b1;
            step <= 3'd0;
         end
         else if (sel && !sel_q && !pins.out_en_n)
         begin
            if (step < 3'd5 && pins.addr == want)
               step <= step + 3'd1;
            else if (step == 3'd5 && pins.addr == nvs_pkg::SAVE_ADDR_LAST)
            begin
               nv <= mem;
               save_count <= save_count + 8'h01;
               {latched, step, busy} <= {1'b0, 3'd0, 8'(BUSY)};
            end
            else if (step == 3'd5
                     && pins.addr == nvs_pkg::RESTORE_ADDR_LAST)
            begin
               mem <= nv;
               restore_count <= restore_count + 8'h01;
               {latched, step, busy} <= {1'b0, 3'd0, 8'(BUSY)};
            end
            else
               step <= 3'(pins.addr == nvs_pkg::SEQ_ADDR0);
         end
         // hardware save only with a latched write
         if (hw_save_req_n_oe && busy == 8'h00 && !dev_drive && latched)
         begin
            nv <= mem;
            save_count <= save_count + 8'h01;
            {latched, dev_drive, busy} <= {1'b0, 1'b1, 8'(BUSY)};
         end
      end
   end
endmodule
`default_nettype wire

// ==== testbench/nvs_host_ctrl_tb.sv ====
/*
 Self-checking bench for the host controller with the device model.
 Assumes the package constants and shortened busy-wait parameters.
*/
`timescale 1ns/1ps
`default_nettype none
module nvs_host_ctrl_tb;
   typedef struct packed {
      nvs_pkg::nvs_req_type rq;
      logic [31:0]          exp;
   } nvs_row_type;
   logic                  ref_clk;
   logic                  rstn;
   logic                  req_valid;
   logic                  req_ready;
   logic                  rsp_valid;
   nvs_pkg::nvs_req_type  req;
   nvs_pkg::nvs_pins_type pins;
   logic [31:0]           rsp_data;
   logic [31:0]           dq_in;
   logic [31:0]           got;
   logic                  hsb_out;
   logic                  hsb_oe;
   logic                  hsb_in;
   logic [7:0]            save_count;
   logic [7:0]            restore_count;
   int                    fail_count;
   int                    samples_checked;
   nvs_row_type           rows [6];

   nvs_host_ctrl #(.SAVE_WAIT(20), .RESTORE_WAIT(20), .CMD_WAIT(20)) dut_u
   (
      .ref_clk(ref_clk), .rstn(rstn), .req_valid(req_valid),
      .req_ready(req_ready), .req(req), .rsp_valid(rsp_valid),
      .rsp_data(rsp_data), .pins(pins), .dq_in(dq_in),
      .hw_save_req_n_out(hsb_out), .hw_save_req_n_oe(hsb_oe),
      .hw_save_req_n_in(hsb_in)
   );
   nvs_dev_model #(.BUSY(10)) dev_u
   (
      .ref_clk(ref_clk), .rstn(rstn), .pins(pins), .dq_in(dq_in),
      .hw_save_req_n_out(hsb_out), .hw_save_req_n_oe(hsb_oe),
      .hw_save_req_n_in(hsb_in), .save_count(save_count),
      .restore_count(restore_count)
   );

   always #25 ref_clk = ~ref_clk;

   ////////////////////////////////////////////////////////////////////////
   task automatic stop_test;
      $display("Checks %0d, mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   task automatic check_val(input string name, input logic [31:0] exp,
                            input logic [31:0] seen);
      samples_checked++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("Error %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // Idle-relevant pin levels packed into one word
   function automatic logic [31:0] pin_view();
      return {16'h0, pins.lane_en_n, pins.chip_sel_second, pins.write_en_n,
              pins.out_en_n, pins.chip_sel_first_n, 4'h0, pins.dq_oe};
   endfunction

   function automatic nvs_row_type mk(nvs_pkg::nvs_op_type op,
      logic [18:0] a, logic [31:0] d, logic [3:0] l, logic [31:0] e);
      mk = '{rq: '{op: op, addr: a, wdata: d, lane_en: l}, exp: e};
   endfunction

   // Holds the request until taken, then waits a bounded time for data
   task automatic do_req(input nvs_pkg::nvs_op_type op,
      input logic [18:0] a, input logic [31:0] d, input logic [3:0] l,
      output logic [31:0] data);
      int n;
      n = 0;
      data = '0;
      @(posedge ref_clk);
      req_valid <= 1'b1;
      req <= '{op: op, addr: a, wdata: d, lane_en: l};
      do
      begin
         @(negedge ref_clk);
         n++;
      end
      while (req_ready !== 1'b1 && n < 400);
      if (n >= 400)
         check_val("ready wait", 32'h0000_0001, 32'h0000_0000);
      @(posedge ref_clk);
      req_valid <= 1'b0;
      if (op == nvs_pkg::NVS_OP_READ)
      begin
         n = 0;
         do
         begin
            @(negedge ref_clk);
            n++;
         end
         while (rsp_valid !== 1'b1 && n < 10);
         data = rsp_data;
         if (n >= 10)
            check_val("response wait", 32'h0000_0001, 32'h0000_0000);
      end
   endtask

   ////////////////////////////////////////////////////////////////////////
   initial
   begin
      logic [31:0] m;
      ref_clk = 1'b0;
      rstn = 1'b0;
      req_valid = 1'b0;
      req = '0;
      fail_count = 0;
      samples_checked = 0;
      rows[0] = mk(nvs_pkg::NVS_OP_WRITE, 19'h8, 32'h1111_2222, 4'hf, 0);
      rows[1] = mk(nvs_pkg::NVS_OP_WRITE, 19'h9, 32'h3333_4444, 4'hf, 0);
      rows[2] = mk(nvs_pkg::NVS_OP_READ, 19'h8, 0, 4'hf, 32'h1111_2222);
      rows[3] = mk(nvs_pkg::NVS_OP_READ, 19'h9, 0, 4'h2, 32'h3333_4444);
      rows[4] = mk(nvs_pkg::NVS_OP_WRITE, 19'h8, 32'haaaa_bbbb, 4'h5, 0);
      rows[5] = mk(nvs_pkg::NVS_OP_READ, 19'h8, 0, 4'hf, 32'h11aa_22bb);
      repeat (5) @(posedge ref_clk);
      @(negedge ref_clk);
      check_val("reset pins", 32'h0000_f700, pin_view());
      check_val("reset hsb", 32'h0000_0000, {31'h0, hsb_oe});
      @(posedge ref_clk);
      rstn <= 1'b1;
      foreach (rows[i])
      begin
         do_req(rows[i].rq.op, rows[i].rq.addr, rows[i].rq.wdata,
                rows[i].rq.lane_en, got);
         m = {{8{rows[i].rq.lane_en[3]}}, {8{rows[i].rq.lane_en[2]}},
              {8{rows[i].rq.lane_en[1]}}, {8{rows[i].rq.lane_en[0]}}};
         if (rows[i].rq.op == nvs_pkg::NVS_OP_READ)
            check_val("row read", rows[i].exp & m, got & m);
      end
      do_req(nvs_pkg::NVS_OP_SAVE, 19'h0, 0, 4'h0, got);
      do_req(nvs_pkg::NVS_OP_WRITE, 19'h8, 32'hdead_beef, 4'hf, got);
      check_val("save count", 32'h1, {24'h0, save_count});
      do_req(nvs_pkg::NVS_OP_RESTORE, 19'h0, 0, 4'h0, got);
      do_req(nvs_pkg::NVS_OP_READ, 19'h8, 0, 4'hf, got);
      check_val("restored", 32'h11aa_22bb, got);
      check_val("restore count", 32'h1, {24'h0, restore_count});
      do_req(nvs_pkg::NVS_OP_SAVE, 19'h0, 0, 4'h1, got);
      do_req(nvs_pkg::NVS_OP_READ, 19'h9, 0, 4'hf, got);
      check_val("skip save", 32'h1, {24'h0, save_count});
      check_val("read after pulse", 32'h3333_4444, got);
      do_req(nvs_pkg::NVS_OP_WRITE, 19'h9, 32'h0102_0304, 4'hf, got);
      do_req(nvs_pkg::NVS_OP_SAVE, 19'h0, 0, 4'h1, got);
      do_req(nvs_pkg::NVS_OP_READ, 19'h9, 0, 4'hf, got);
      check_val("hw save", 32'h2, {24'h0, save_count});
      check_val("read after save", 32'h0102_0304, got);
      // Reset in mid-run: pins idle again, stored data kept
      @(posedge ref_clk);
      rstn <= 1'b0;
      @(negedge ref_clk);
      check_val("midrun pins", 32'h0000_f700, pin_view());
      check_val("midrun hsb", 32'h0000_0000, {31'h0, hsb_oe});
      repeat (5) @(posedge ref_clk);
      rstn <= 1'b1;
      do_req(nvs_pkg::NVS_OP_READ, 19'h9, 0, 4'hf, got);
      check_val("read after reset", 32'h0102_0304, got);
      stop_test;
   end

   initial
   begin
      repeat (5000) @(posedge ref_clk);
      fail_count++;
      stop_test;
   end
endmodule
`default_nettype wire
